// ===== core/cpu_core_pkg.sv
package cpu_core_pkg;

  // Register byte addresses
  localparam logic [11:0] STATUS_ADDR  = 12'h000;
  localparam logic [11:0] CONTROL_ADDR = 12'h004;

  // Reset values
  localparam logic [15:0] STATUS_RESET  = 16'h0000;
  localparam logic [15:0] CONTROL_RESET = 16'h0020;

  // Status field positions
  localparam int ST_CLIP_A     = 13;
  localparam int ST_CLIP_B     = 12;
  localparam int ST_CLIP_ANY   = 10;
  localparam int ST_HALF_CARRY = 8;
  localparam int ST_PRIO_LO    = 5;
  localparam int ST_REPEAT     = 4;
  localparam int ST_N          = 3;
  localparam int ST_WRAP       = 2;
  localparam int ST_Z          = 1;
  localparam int ST_C          = 0;

  // Core control field positions
  localparam int CC_MUL_UNSIGNED = 12;
  localparam int CC_EARLY_EXIT   = 11;
  localparam int CC_DEPTH_LO     = 8;
  localparam int CC_CLIP_A_EN    = 7;
  localparam int CC_CLIP_B_EN    = 6;
  localparam int CC_STORE_CLIP   = 5;
  localparam int CC_WIDE_CLIP    = 4;
  localparam int CC_PRIO_MSB     = 3;
  localparam int CC_PROG_WIN     = 2;
  localparam int CC_ROUNDING     = 1;
  localparam int CC_INT_FRAC     = 0;

  typedef enum logic [3:0] {
    OP_ADD    = 4'h0,
    OP_ADDC   = 4'h1,
    OP_SUB    = 4'h2,
    OP_SUBB   = 4'h3,
    OP_AND    = 4'h4,
    OP_IOR    = 4'h5,
    OP_XOR    = 4'h6,
    OP_SHL    = 4'h7,
    OP_LSR    = 4'h8,
    OP_ASR    = 4'h9,
    OP_MUL_SS = 4'hA,
    OP_MUL_UU = 4'hB,
    OP_MUL_SU = 4'hC,
    OP_MUL_US = 4'hD,
    OP_MUL_SL = 4'hE,
    OP_MUL_UL = 4'hF
  } alu_op_t;

  typedef struct packed {
    logic        valid;
    alu_op_t     op;
    logic        byte_mode;
    logic [15:0] a;
    logic [15:0] b;
  } alu_req_t;

  typedef struct packed {
    logic        valid;
    logic [31:0] data;
  } alu_res_t;

  typedef struct packed {
    logic mul_unsigned;
    logic acc_a_clip_en;
    logic acc_b_clip_en;
    logic store_clip_en;
    logic wide_clip_sel;
    logic program_window_en;
    logic rounding_sel;
    logic int_frac_sel;
  } dsp_mode_t;

  typedef enum logic {
    APB_IDLE = 1'h0,
    APB_DONE = 1'h1
  } apb_state_t;

endpackage

// ===== core/cpu_status_core_control_alu.sv
// Implementation choices: register access over APB and the placing of the registers.
`timescale 1ns/1ps
module cpu_status_core_control_alu
  import cpu_core_pkg::*;
(
  input  wire logic        CLK_I,
  input  wire logic        SRST_I,
  input  wire logic        PSEL_I,
  input  wire logic        PENABLE_I,
  input  wire logic        PWRITE_I,
  input  wire logic [11:0] PADDR_I,
  input  wire logic [31:0] PWDATA_I,
  output logic      [31:0] PRDATA_O,
  output logic             PREADY_O,
  output logic             PSLVERR_O,
  input  wire logic        NESTING_OFF_I,
  input  wire logic        PRIORITY_LOAD_I,
  input  wire logic [3:0]  PRIORITY_VALUE_I,
  input  wire logic        REPEAT_ACTIVE_I,
  input  wire logic [2:0]  LOOP_DEPTH_I,
  input  wire logic        ACC_A_CLIP_EVT_I,
  input  wire logic        ACC_B_CLIP_EVT_I,
  input  wire alu_req_t    ALU_REQ_I,
  output alu_res_t         ALU_RES_O,
  output logic      [3:0]  PRIORITY_LEVEL_O,
  output logic             USER_IRQ_OFF_O,
  output dsp_mode_t        DSP_MODE_O,
  output logic             EARLY_EXIT_O
);

  // Top bit of a byte or word
  function automatic logic top_bit(
    input logic [15:0] v,
    input logic        byte_sel
  );
    top_bit = byte_sel ? v[7] : v[15];
  endfunction

  // Extend to 17 bits, signed or unsigned
  function automatic logic [16:0] ext17(
    input logic [15:0] v,
    input logic        sg
  );
    ext17 = {sg & v[15], v};
  endfunction

  // Hardware update wins over software write
  function automatic logic flag_next(
    input logic hw,
    input logic hw_val,
    input logic sw,
    input logic sw_val,
    input logic old
  );
    flag_next = hw ? hw_val : (sw ? sw_val : old);
  endfunction

  apb_state_t  state;
  logic [2:0]  prio;
  logic        msb;
  logic        rep;
  logic        n;
  logic        wrap;
  logic        z;
  logic        c;
  logic        half_c;
  logic        clip_a;
  logic        clip_b;
  logic [2:0]  depth;
  dsp_mode_t   mode;

  // Bus decode
  wire         hit_st   = PADDR_I == STATUS_ADDR;
  wire         hit_cc   = PADDR_I == CONTROL_ADDR;
  wire         mapped   = hit_st | hit_cc;
  wire         access   = PSEL_I & PENABLE_I;
  wire         wr_fire  = access & PREADY_O & PWRITE_I & mapped;
  wire         st_wr    = wr_fire & hit_st;
  wire         cc_wr    = wr_fire & hit_cc;
  wire  [15:0] w        = PWDATA_I[15:0];

  // Register read views
  wire  [15:0] status_rd = {2'h0, clip_a, clip_b, 1'h0, clip_a | clip_b, 1'h0, half_c,
                            prio, rep, n, wrap, z, c};
  wire  [15:0] control_rd = {3'h0, mode.mul_unsigned, 1'h0, depth,
                             mode.acc_a_clip_en, mode.acc_b_clip_en,
                             mode.store_clip_en, mode.wide_clip_sel,
                             msb, mode.program_window_en,
                             mode.rounding_sel, mode.int_frac_sel};
  wire  [15:0] read_mux = hit_st ? status_rd :
                          (hit_cc ? control_rd : 16'h0000);

  // Priority field and its top bit
  wire         prio_sw   = st_wr & ~NESTING_OFF_I;
  wire  [2:0]  next_prio = PRIORITY_LOAD_I ? PRIORITY_VALUE_I[2:0] :
                           (prio_sw ? w[ST_PRIO_LO +: 3] : prio);
  wire         msb_clr   = cc_wr & ~w[CC_PRIO_MSB];
  wire         next_msb  = PRIORITY_LOAD_I ? PRIORITY_VALUE_I[3] :
                           (msb & ~msb_clr);
  wire         next_irq_off = next_msb | (&next_prio);

  // Sticky clip flags, event wins over clear
  wire         clip_a_clr  = st_wr & (~w[ST_CLIP_A] | ~w[ST_CLIP_ANY]);
  wire         clip_b_clr  = st_wr & (~w[ST_CLIP_B] | ~w[ST_CLIP_ANY]);
  wire         next_clip_a = ACC_A_CLIP_EVT_I | (clip_a & ~clip_a_clr);
  wire         next_clip_b = ACC_B_CLIP_EVT_I | (clip_b & ~clip_b_clr);

  // ALU operand preparation
  alu_req_t    q;
  assign q = ALU_REQ_I;
  wire         bm       = q.byte_mode;
  wire         is_sub   = (q.op == OP_SUB) | (q.op == OP_SUBB);
  wire         use_c    = (q.op == OP_ADDC) | (q.op == OP_SUBB);
  wire         is_arith = q.op <= OP_SUBB;
  wire         is_shift = (q.op == OP_SHL) | (q.op == OP_LSR) |
                          (q.op == OP_ASR);
  wire         is_logic = (q.op == OP_AND) | (q.op == OP_IOR) |
                          (q.op == OP_XOR);
  wire         is_mul   = q.op >= OP_MUL_SS;
  wire  [15:0] ax       = bm ? {8'h00, q.a[7:0]} : q.a;
  wire  [15:0] binv     = is_sub ? ~q.b : q.b;
  wire  [15:0] bx       = bm ? {8'h00, binv[7:0]} : binv;
  wire         cin      = use_c ? c : is_sub;

  // Adder with digit carry taps
  wire  [16:0] sum      = {1'h0, ax} + {1'h0, bx} + {16'h0000, cin};
  wire  [4:0]  nib      = {1'h0, ax[3:0]} + {1'h0, bx[3:0]} + {4'h0, cin};
  wire  [8:0]  oct      = {1'h0, ax[7:0]} + {1'h0, bx[7:0]} + {8'h00, cin};
  wire         add_c    = bm ? sum[8] : sum[16];
  wire         add_half_c = bm ? nib[4] : oct[8];

  // Shifts by one place
  wire  [15:0] shl_v    = {ax[14:0], 1'h0};
  wire  [15:0] lsr_v    = {1'h0, ax[15:1]};
  wire  [15:0] asr_v    = bm ? {8'h00, ax[7], ax[7:1]} :
                               {ax[15], ax[15:1]};
  wire         shl_c    = top_bit(ax, bm);
  wire         lsr_c    = ax[0];

  logic [15:0] raw;
  logic        sh_c;

  always_comb begin
    raw  = 16'h0000;
    sh_c = 1'h0;
    case (q.op)
      OP_ADD, OP_ADDC, OP_SUB, OP_SUBB: begin
        raw = sum[15:0];
      end
      OP_AND: begin
        raw = ax & bx;
      end
      OP_IOR: begin
        raw = ax | bx;
      end
      OP_XOR: begin
        raw = ax ^ bx;
      end
      OP_SHL: begin
        raw  = shl_v;
        sh_c = shl_c;
      end
      OP_LSR: begin
        raw  = lsr_v;
        sh_c = lsr_c;
      end
      OP_ASR: begin
        raw  = asr_v;
        sh_c = lsr_c;
      end
      default: begin
        raw  = 16'h0000;
        sh_c = 1'h0;
      end
    endcase
  end

  // Result width and flags
  wire  [15:0] resm     = bm ? {8'h00, raw[7:0]} : raw;
  wire         r_zero   = resm == 16'h0000;
  wire         r_neg    = top_bit(resm, bm);
  wire         r_wrap   = (top_bit(ax, bm) == top_bit(bx, bm)) &
                          (top_bit(resm, bm) != top_bit(ax, bm));
  wire         r_z      = use_c ? (z & r_zero) : r_zero;
  wire         r_c      = is_arith ? add_c : sh_c;
  wire         fire     = q.valid;
  wire         aff_nz   = fire & (is_arith | is_shift | is_logic);
  wire         aff_c    = fire & (is_arith | is_shift);
  wire         aff_wrap = fire & is_arith;

  wire         next_n      = flag_next(aff_nz, r_neg, st_wr, w[ST_N], n);
  wire         next_wrap   = flag_next(aff_wrap, r_wrap, st_wr, w[ST_WRAP], wrap);
  wire         next_z      = flag_next(aff_nz, r_z, st_wr, w[ST_Z], z);
  wire         next_c      = flag_next(aff_c, r_c, st_wr, w[ST_C], c);
  wire         next_half_c = flag_next(aff_wrap, add_half_c, st_wr, w[ST_HALF_CARRY], half_c);

  // Multiplier signedness and operands
  wire         lit      = (q.op == OP_MUL_SL) | (q.op == OP_MUL_UL);
  wire         a_sg     = ~bm & ((q.op == OP_MUL_SS) | (q.op == OP_MUL_SU) |
                          (q.op == OP_MUL_SL));
  wire         b_sg     = ~bm & ((q.op == OP_MUL_SS) |
                          (q.op == OP_MUL_US));
  wire  [15:0] mb_v     = lit ? {11'h000, q.b[4:0]} :
                          (bm ? {8'h00, q.b[7:0]} : q.b);
  wire signed [16:0] ma = $signed(ext17(ax, a_sg));
  wire signed [16:0] mb = $signed(ext17(mb_v, b_sg));
  wire signed [33:0] prod = ma * mb;
  wire  [31:0] next_data = is_mul ? prod[31:0] : {16'h0000, resm};

  // Control write decode
  dsp_mode_t   next_mode;
  always_comb begin
    next_mode = mode;
    if (cc_wr) begin
      next_mode.mul_unsigned      = w[CC_MUL_UNSIGNED];
      next_mode.acc_a_clip_en     = w[CC_CLIP_A_EN];
      next_mode.acc_b_clip_en     = w[CC_CLIP_B_EN];
      next_mode.store_clip_en     = w[CC_STORE_CLIP];
      next_mode.wide_clip_sel     = w[CC_WIDE_CLIP];
      next_mode.program_window_en = w[CC_PROG_WIN];
      next_mode.rounding_sel      = w[CC_ROUNDING];
      next_mode.int_frac_sel      = w[CC_INT_FRAC];
    end
  end

  // APB slave, one wait state per access
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      state     <= APB_IDLE;
      PREADY_O  <= 1'h0;
      PSLVERR_O <= 1'h0;
      PRDATA_O  <= 32'h00000000;
    end else begin
      case (state)
        APB_IDLE: begin
          if (access) begin
            state     <= APB_DONE;
            PREADY_O  <= 1'h1;
            PSLVERR_O <= ~mapped;
            PRDATA_O  <= PWRITE_I ? 32'h00000000 : {16'h0000, read_mux};
          end
        end
        APB_DONE: begin
          state     <= APB_IDLE;
          PREADY_O  <= 1'h0;
          PSLVERR_O <= 1'h0;
        end
        default: begin
          state    <= APB_IDLE;
          PREADY_O <= 1'h0;
        end
      endcase
    end
  end

  // Status register
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      prio   <= STATUS_RESET[ST_PRIO_LO +: 3];
      rep    <= STATUS_RESET[ST_REPEAT];
      n      <= STATUS_RESET[ST_N];
      wrap   <= STATUS_RESET[ST_WRAP];
      z      <= STATUS_RESET[ST_Z];
      c      <= STATUS_RESET[ST_C];
      half_c <= STATUS_RESET[ST_HALF_CARRY];
      clip_a <= STATUS_RESET[ST_CLIP_A];
      clip_b <= STATUS_RESET[ST_CLIP_B];
    end else begin
      prio   <= next_prio;
      rep    <= REPEAT_ACTIVE_I;
      n      <= next_n;
      wrap   <= next_wrap;
      z      <= next_z;
      c      <= next_c;
      half_c <= next_half_c;
      clip_a <= next_clip_a;
      clip_b <= next_clip_b;
    end
  end

  // Core control register and outputs
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      msb                    <= CONTROL_RESET[CC_PRIO_MSB];
      depth                  <= CONTROL_RESET[CC_DEPTH_LO +: 3];
      mode.mul_unsigned      <= CONTROL_RESET[CC_MUL_UNSIGNED];
      mode.acc_a_clip_en     <= CONTROL_RESET[CC_CLIP_A_EN];
      mode.acc_b_clip_en     <= CONTROL_RESET[CC_CLIP_B_EN];
      mode.store_clip_en     <= CONTROL_RESET[CC_STORE_CLIP];
      mode.wide_clip_sel     <= CONTROL_RESET[CC_WIDE_CLIP];
      mode.program_window_en <= CONTROL_RESET[CC_PROG_WIN];
      mode.rounding_sel      <= CONTROL_RESET[CC_ROUNDING];
      mode.int_frac_sel      <= CONTROL_RESET[CC_INT_FRAC];
      DSP_MODE_O             <= dsp_mode_t'(8'h10);
      EARLY_EXIT_O           <= 1'h0;
      PRIORITY_LEVEL_O       <= 4'h0;
      USER_IRQ_OFF_O         <= 1'h0;
    end else begin
      msb              <= next_msb;
      depth            <= LOOP_DEPTH_I;
      mode             <= next_mode;
      DSP_MODE_O       <= next_mode;
      EARLY_EXIT_O     <= cc_wr & w[CC_EARLY_EXIT];
      PRIORITY_LEVEL_O <= {next_msb, next_prio};
      USER_IRQ_OFF_O   <= next_irq_off;
    end
  end

  // ALU result register
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      ALU_RES_O <= '0;
    end else begin
      ALU_RES_O.valid <= fire;
      ALU_RES_O.data  <= next_data;
    end
  end

endmodule

// ===== bench/cpu_status_core_control_alu_props.sv
`timescale 1ns/1ps
module cpu_status_core_control_alu_props
  import cpu_core_pkg::*;
(
  input logic        CLK_I,
  input logic        SRST_I,
  input logic        PSEL_I,
  input logic        PENABLE_I,
  input logic        PWRITE_I,
  input logic [11:0] PADDR_I,
  input logic [31:0] PWDATA_I,
  input logic [31:0] PRDATA_O,
  input logic        PREADY_O,
  input logic        PRIORITY_LOAD_I,
  input logic [3:0]  PRIORITY_VALUE_I,
  input alu_req_t    ALU_REQ_I,
  input alu_res_t    ALU_RES_O,
  input logic [3:0]  PRIORITY_LEVEL_O,
  input logic        USER_IRQ_OFF_O,
  input dsp_mode_t   DSP_MODE_O,
  input logic        EARLY_EXIT_O
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (SRST_I);
  wire cc_wr = PSEL_I && PENABLE_I && PREADY_O && PWRITE_I && PADDR_I == CONTROL_ADDR;
  AST_USER_OFF: assert property (USER_IRQ_OFF_O == (PRIORITY_LEVEL_O[3] || PRIORITY_LEVEL_O[2:0] == 3'h7))
    else $error("user interrupt disable wrong");
  AST_LOAD: assert property (PRIORITY_LOAD_I |=> PRIORITY_LEVEL_O == $past(PRIORITY_VALUE_I))
    else $error("priority load wrong");
  AST_ALU_VALID: assert property (ALU_RES_O.valid == $past(ALU_REQ_I.valid))
    else $error("alu valid timing wrong");
  AST_MUL_UU: assert property (ALU_REQ_I.valid && ALU_REQ_I.op == OP_MUL_UU && !ALU_REQ_I.byte_mode |=>
    ALU_RES_O.data == {16'h0000, $past(ALU_REQ_I.a)} * {16'h0000, $past(ALU_REQ_I.b)})
    else $error("unsigned multiply wrong");
  AST_EARLY_EXIT: assert property (cc_wr && PWDATA_I[11] |=> EARLY_EXIT_O ##1 !EARLY_EXIT_O)
    else $error("early exit pulse wrong");
  AST_CC_RSVD: assert property (PREADY_O && !PWRITE_I && PADDR_I == CONTROL_ADDR |->
    PRDATA_O[31:13] == 19'h0 && !PRDATA_O[11]) else $error("reserved control bits not zero");
  AST_MODE_WR: assert property (cc_wr |=> DSP_MODE_O ==
    {$past(PWDATA_I[12]), $past(PWDATA_I[7:4]), $past(PWDATA_I[2:0])}) else $error("dsp mode not updated");
  AST_MODE_RST: assert property ($fell(SRST_I) |-> DSP_MODE_O == 8'h10)
    else $error("dsp mode reset wrong");
  AST_READY: assert property ($rose(PENABLE_I) && PSEL_I |=> PREADY_O ##1 !PREADY_O)
    else $error("register access answer wrong");
endmodule

// ===== bench/cpu_status_core_control_alu_tb_top.sv
`timescale 1ns/1ps
module cpu_status_core_control_alu_tb_top
  import cpu_core_pkg::*;
;
  logic        clk, srst, psel, penable, pwrite, nest_off, prio_load, rep_act, clip_a, clip_b;
  logic        ready, slverr, irq_off, early, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  prio_val, level;
  logic [2:0]  depth;
  alu_req_t    alu_req;
  alu_res_t    alu_res;
  dsp_mode_t   dsp_mode;
  int          fails, n_tests;

  cpu_status_core_control_alu u_dut (.CLK_I(clk), .SRST_I(srst), .PSEL_I(psel), .PENABLE_I(penable),
    .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(ready),
    .PSLVERR_O(slverr), .NESTING_OFF_I(nest_off), .PRIORITY_LOAD_I(prio_load), .PRIORITY_VALUE_I(prio_val),
    .REPEAT_ACTIVE_I(rep_act), .LOOP_DEPTH_I(depth), .ACC_A_CLIP_EVT_I(clip_a), .ACC_B_CLIP_EVT_I(clip_b),
    .ALU_REQ_I(alu_req), .ALU_RES_O(alu_res), .PRIORITY_LEVEL_O(level), .USER_IRQ_OFF_O(irq_off),
    .DSP_MODE_O(dsp_mode), .EARLY_EXIT_O(early));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task summarize;
    $display("tests %0d fails %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task apb(input logic wr, input logic [11:0] ad, input logic [31:0] wd, output logic [31:0] d, output logic e);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (ready !== 1'b1 && n < 20);
    if (n >= 20) begin
      fails++;
      summarize();
    end
    d = prdata;
    e = slverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task alu(input alu_op_t op, input logic bm, input logic [15:0] a, input logic [15:0] b,
           input logic [31:0] d, input logic f, input logic [3:0] fl);
    alu_req <= '{1'b1, op, bm, a, b};
    @(posedge clk);
    alu_req.valid <= 1'b0;
    @(posedge clk);
    chk({31'h0, alu_res.valid}, 32'h1);
    chk(alu_res.data, d);
    if (f) begin
      apb(1'b0, STATUS_ADDR, 32'h0, rd, er);
      chk({28'h0, rd[3:0]}, {28'h0, fl});
    end
  endtask

  task pulse_prio(input logic [3:0] v);
    prio_val <= v;
    prio_load <= 1'b1;
    @(posedge clk);
    prio_load <= 1'b0;
    @(posedge clk);
  endtask

  initial begin
    {srst, psel, penable, pwrite, nest_off, prio_load, rep_act, clip_a, clip_b} = 9'h100;
    {paddr, pwdata, prio_val, alu_req} = '0;
    depth = 3'h5;
    fails = 0;
    n_tests = 0;
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    apb(1'b0, STATUS_ADDR, 32'h0, rd, er); chk(rd, 32'h0);
    apb(1'b0, CONTROL_ADDR, 32'h0, rd, er); chk(rd, 32'h0520);
    apb(1'b0, 12'h008, 32'h0, rd, er); chk({rd[30:0], er}, 32'h1);
    apb(1'b1, CONTROL_ADDR, 32'hFFFFFFFF, rd, er);
    apb(1'b0, CONTROL_ADDR, 32'h0, rd, er); chk(rd, 32'h15F7);
    chk(dsp_mode, 32'hFF);
    depth <= 3'h7;
    apb(1'b1, CONTROL_ADDR, 32'h0, rd, er);
    apb(1'b0, CONTROL_ADDR, 32'h0, rd, er); chk(rd, 32'h0700);
    chk(dsp_mode, 32'h00);
    pulse_prio(4'hF); chk({level, irq_off}, 32'h1F);
    apb(1'b0, CONTROL_ADDR, 32'h0, rd, er); chk(rd[3], 32'h1);
    apb(1'b1, CONTROL_ADDR, 32'h0, rd, er); chk({level, irq_off}, 32'h0F);
    apb(1'b1, STATUS_ADDR, 32'h0060, rd, er); chk({level, irq_off}, 32'h06);
    nest_off <= 1'b1;
    apb(1'b1, STATUS_ADDR, 32'h00A0, rd, er);
    apb(1'b0, STATUS_ADDR, 32'h0, rd, er); chk(rd[7:5], 32'h3);
    nest_off <= 1'b0;
    clip_a <= 1'b1;
    clip_b <= 1'b1;
    rep_act <= 1'b1;
    @(posedge clk);
    clip_a <= 1'b0;
    clip_b <= 1'b0;
    apb(1'b1, STATUS_ADDR, 32'h3460, rd, er);
    apb(1'b0, STATUS_ADDR, 32'h0, rd, er); chk(rd, 32'h3470);
    apb(1'b1, STATUS_ADDR, 32'h3060, rd, er);
    apb(1'b0, STATUS_ADDR, 32'h0, rd, er); chk(rd, 32'h0070);
    rep_act <= 1'b0;
    alu(OP_ADD, 1'b0, 16'h7FFF, 16'h0001, 32'h8000, 1'b1, 4'hC);
    alu(OP_ADD, 1'b0, 16'hFFFF, 16'h0001, 32'h0000, 1'b1, 4'h3);
    alu(OP_SUB, 1'b0, 16'h0000, 16'h0001, 32'hFFFF, 1'b1, 4'h8);
    alu(OP_SUB, 1'b0, 16'h0005, 16'h0003, 32'h0002, 1'b1, 4'h1);
    alu(OP_ADD, 1'b1, 16'h007F, 16'h0001, 32'h0080, 1'b1, 4'hC);
    alu(OP_ADD, 1'b1, 16'h12FF, 16'h0001, 32'h0000, 1'b1, 4'h3);
    alu(OP_XOR, 1'b0, 16'hF0F0, 16'h0FF0, 32'hFF00, 1'b1, 4'h9);
    alu(OP_LSR, 1'b0, 16'h0003, 16'h0000, 32'h0001, 1'b1, 4'h1);
    alu(OP_MUL_SS, 1'b0, 16'hFFFF, 16'h0002, 32'hFFFFFFFE, 1'b0, 4'h0);
    alu(OP_MUL_UU, 1'b0, 16'hFFFF, 16'h0002, 32'h0001FFFE, 1'b0, 4'h0);
    alu(OP_MUL_SU, 1'b0, 16'hFFFE, 16'h0003, 32'hFFFFFFFA, 1'b0, 4'h0);
    alu(OP_MUL_US, 1'b0, 16'h0003, 16'hFFFE, 32'hFFFFFFFA, 1'b0, 4'h0);
    alu(OP_MUL_SL, 1'b0, 16'hFFFF, 16'h0023, 32'hFFFFFFFD, 1'b0, 4'h0);
    alu(OP_MUL_UL, 1'b0, 16'hFFFF, 16'h0023, 32'h0002FFFD, 1'b0, 4'h0);
    alu(OP_MUL_SS, 1'b1, 16'h12FF, 16'h34FF, 32'h0000FE01, 1'b0, 4'h0);
    summarize();
  end
endmodule

bind cpu_status_core_control_alu cpu_status_core_control_alu_props u_props (.CLK_I(CLK_I), .SRST_I(SRST_I),
  .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I),
  .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O), .PRIORITY_LOAD_I(PRIORITY_LOAD_I),
  .PRIORITY_VALUE_I(PRIORITY_VALUE_I), .ALU_REQ_I(ALU_REQ_I), .ALU_RES_O(ALU_RES_O),
  .PRIORITY_LEVEL_O(PRIORITY_LEVEL_O), .USER_IRQ_OFF_O(USER_IRQ_OFF_O), .DSP_MODE_O(DSP_MODE_O),
  .EARLY_EXIT_O(EARLY_EXIT_O));
